/* core/itam_params.svh */
// Constants of the time-out and address match block: map, fields, counts.
// Assumes inclusion by bare name from the package and design modules.
// Function
// - Enable bit runs a 14-bit time-out counter after the serial flag clears.
// - Writing one to the serial flag resets the counter; restart after flag clears.
// - Prescale select divides the counter input clock by four.
// - Hardware sets the time-out flag on time-out; it stays until cleared.
// - A set time-out flag requests an interrupt only when interrupt enable is one.
// - Writing one clears the time-out flag; writing zero leaves it.
// - In master mode own-address registers are ignored for recognition.
// - In slave mode respond when any of four masked own addresses matches.
// - Bit zero of each own-address register enables general call recognition.
// - A mask bit of one makes that received address bit don't-care.
// - A mask bit of zero demands an exact match of that bit.
// - Four mask registers, each paired with one own-address register.
// - Hardware sets the serial flag on each defined bus state.
// - Interrupt enable is bit seven of the control register and gates interrupts.
// - With general call enabled, the all-zero address is a general call.
`ifndef ITAM_PARAMS_SVH
`define ITAM_PARAMS_SVH
`define ITAM_OFF_CTL   8'h00
`define ITAM_OFF_OWN0  8'h04
`define ITAM_OFF_TOC   8'h14
`define ITAM_OFF_OWN1  8'h18
`define ITAM_OFF_OWN2  8'h1C
`define ITAM_OFF_OWN3  8'h20
`define ITAM_OFF_MSK0  8'h24
`define ITAM_OFF_MSK1  8'h28
`define ITAM_OFF_MSK2  8'h2C
`define ITAM_OFF_MSK3  8'h30
`define ITAM_OFF_STS   8'h44
`define ITAM_OFF_IEN   8'h48
`define ITAM_CTL_INT_EN 7
`define ITAM_CTL_SI    3
`define ITAM_TOC_EN    2
`define ITAM_TOC_PRESC 1
`define ITAM_TOC_FLAG  0
`define ITAM_EV_TO     0
`define ITAM_EV_SI     1
`define ITAM_EV_HIT    2
`define ITAM_IEN_RST   3'h7
`define ITAM_TO_TERM   14'h3FFF
`define ITAM_PRESC_TOP 2'h3
`define ITAM_GENCALL_ADDR 7'h00
`endif

/* core/itam_pkg.sv */
// Types shared by the time-out and address match block.
// Assumes the constants header sits beside it.
package itam_pkg;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } itam_avs_req_t;

   typedef struct packed {
      logic [6:0] addr;
      logic       gencall_en;
   } itam_own_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK  = 2'b10
   } itam_bus_st_t;
endpackage : itam_pkg

/* core/itam_timeout.sv */
// Bus time-out counter with optional divide-by-four prescale.
// Assumes enable, prescale and serial flag come from the same clock.
`timescale 1ns/100ps
`include "itam_params.svh"
module itam_timeout #(
   parameter logic [13:0] TERM = `ITAM_TO_TERM
) (
   input  logic clk_sys,
   input  logic rst,
   input  logic enable,
   input  logic prescale,
   input  logic si,
   input  logic restart,
   output logic expire
);
   import itam_pkg::*;
   logic [1:0]  pre_q;
   logic [13:0] cnt_q;
   logic        done_q;
   logic        run;
   logic        tick;
   logic        last;

   assign run  = enable & ~si & ~done_q;
   assign tick = ~prescale | (pre_q == `ITAM_PRESC_TOP);
   assign last = tick & (cnt_q == TERM);

   always_ff @(posedge clk_sys) begin
      if (rst | ~enable | si | restart) begin
         pre_q  <= '0;
         cnt_q  <= '0;
         done_q <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= run & last;
         if (run) begin
            pre_q <= pre_q + 2'h1;
            if (last) begin
               done_q <= 1'b1;
            end else if (tick) begin
               cnt_q <= cnt_q + 14'h1;
            end
         end
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   prescale_hold_a: assert property (
      run && prescale && !restart && pre_q != `ITAM_PRESC_TOP |=> $stable(cnt_q))
      else $error("counter moved between prescale ticks");
   stop_at_end_a: assert property (
      done_q && enable && !si && !restart |=> $stable(cnt_q) && !expire)
      else $error("counter ran on after time-out");
endmodule : itam_timeout

/* core/itam_match.sv */
// Slave address recognition against four masked own addresses.
// Assumes rx_addr holds the received address byte while rx_valid is high.
`timescale 1ns/100ps
`include "itam_params.svh"
module itam_match (
   input  logic                       rx_valid,
   input  logic [7:0]                 rx_addr,
   input  logic                       bus_master,
   input  itam_pkg::itam_own_t [3:0]  own,
   input  logic [3:0][6:0]            mask,
   output logic                       hit,
   output logic                       gencall,
   output logic [1:0]                 idx
);
   import itam_pkg::*;
   logic [6:0] ra;
   logic [3:0] ent;
   logic [3:0] gen_ok;

   assign ra = rx_addr[7:1];

   for (genvar g = 0; g < 4; g++) begin : g_ent
      // All-zero address never matches as a plain address
      assign gen_ok[g] = own[g].gencall_en & (ra == `ITAM_GENCALL_ADDR);
      assign ent[g] = gen_ok[g] | ((ra != `ITAM_GENCALL_ADDR) &
                      (((ra ^ own[g].addr) & ~mask[g]) == '0));
   end

   always_comb begin
      hit = rx_valid & ~bus_master & (|ent);
      gencall = hit & (|gen_ok);
      idx = 2'h0;
      for (int k = 3; k >= 0; k--) begin
         if (ent[k]) begin
            idx = 2'(k);
         end
      end
   end
endmodule : itam_match

/* core/itam_top.sv */
// Time-out counter and own-address match registers behind Avalon-MM.
// Assumes the transfer state machine on the same clock drives state_event,
// bus_master and the received address byte.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "itam_params.svh"
module itam_top #(
   parameter logic [13:0] TO_LIMIT = `ITAM_TO_TERM
) (
   input  logic                    clk_sys,
   input  logic                    rst,
   input  itam_pkg::itam_avs_req_t avs_req,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   input  logic                    state_event,
   input  logic                    bus_master,
   input  logic                    rx_valid,
   input  logic [7:0]              rx_addr,
   output logic                    irq,
   output logic                    addr_hit,
   output logic                    gencall_hit,
   output logic [1:0]              hit_index
);
   import itam_pkg::*;

   localparam logic [7:0] OWN_OFF [4] = '{
      `ITAM_OFF_OWN0,
      `ITAM_OFF_OWN1,
      `ITAM_OFF_OWN2,
      `ITAM_OFF_OWN3
   };
   localparam logic [7:0] MSK_OFF [4] = '{
      `ITAM_OFF_MSK0,
      `ITAM_OFF_MSK1,
      `ITAM_OFF_MSK2,
      `ITAM_OFF_MSK3
   };

   itam_bus_st_t     st_q;
   logic             wr_go;
   logic [7:0]       wd;
   logic             wr_ctl;
   logic             wr_toc;
   logic             wr_sts;
   logic             wr_ien;
   logic [31:0]      rd_d;
   logic             int_en_q;
   logic             si_q;
   logic             en_q;
   logic             prescale_q;
   logic [2:0]       sts_q;
   logic [2:0]       ien_q;
   logic [2:0]       ev;
   logic [2:0]       clr;
   itam_own_t [3:0]  own_q;
   logic [3:0][6:0]  mask_q;
   logic             to_expire;
   logic             to_restart;
   logic             m_hit;
   logic             m_gencall;
   logic [1:0]       m_idx;

   // Bus slave: one wait state, then a single ready cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q            <= ST_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (avs_req.read | avs_req.write) begin
                  st_q            <= ST_ACK;
                  avs_waitrequest <= 1'b0;
               end
            end
            ST_ACK: begin
               st_q            <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               st_q            <= ST_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Write takes effect at the edge the master sees waitrequest low
   assign wr_go  = avs_req.write & (st_q == ST_ACK) & avs_req.byteenable[0];
   assign wd     = avs_req.writedata[7:0];
   assign wr_ctl = wr_go & (avs_req.address == `ITAM_OFF_CTL);
   assign wr_toc = wr_go & (avs_req.address == `ITAM_OFF_TOC);
   assign wr_sts = wr_go & (avs_req.address == `ITAM_OFF_STS);
   assign wr_ien = wr_go & (avs_req.address == `ITAM_OFF_IEN);

   always_comb begin
      rd_d = '0;
      case (avs_req.address)
         `ITAM_OFF_CTL: begin
            rd_d[`ITAM_CTL_INT_EN] = int_en_q;
            rd_d[`ITAM_CTL_SI] = si_q;
         end
         `ITAM_OFF_TOC: begin
            rd_d[`ITAM_TOC_EN]   = en_q;
            rd_d[`ITAM_TOC_PRESC] = prescale_q;
            rd_d[`ITAM_TOC_FLAG] = sts_q[`ITAM_EV_TO];
         end
         `ITAM_OFF_STS: begin
            rd_d[2:0] = sts_q;
         end
         `ITAM_OFF_IEN: begin
            rd_d[2:0] = ien_q;
         end
         default: begin
            rd_d = '0;
         end
      endcase
      for (int k = 0; k < 4; k++) begin
         if (avs_req.address == OWN_OFF[k]) begin
            rd_d[7:0] = own_q[k];
         end
         if (avs_req.address == MSK_OFF[k]) begin
            rd_d[7:1] = mask_q[k];
         end
      end
   end

   // Read data captured on entry to the ready cycle; unmapped reads give zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_readdata <= '0;
      end else if (st_q == ST_IDLE && avs_req.read) begin
         avs_readdata <= rd_d;
      end
   end

   // Control register: interrupt enable and serial flag
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         int_en_q <= 1'b0;
      end else if (wr_ctl) begin
         int_en_q <= wd[`ITAM_CTL_INT_EN];
      end
   end

   // A new bus state outranks a clearing write in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         si_q <= 1'b0;
      end else if (state_event) begin
         si_q <= 1'b1;
      end else if (wr_ctl && wd[`ITAM_CTL_SI]) begin
         si_q <= 1'b0;
      end
   end

   assign to_restart = wr_ctl & wd[`ITAM_CTL_SI];

   // Time-out control register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q       <= 1'b0;
         prescale_q <= 1'b0;
      end else if (wr_toc) begin
         en_q       <= wd[`ITAM_TOC_EN];
         prescale_q <= wd[`ITAM_TOC_PRESC];
      end
   end

   itam_timeout #(
      .TERM    (TO_LIMIT)
   ) u_timeout (
      .clk_sys (clk_sys),
      .rst     (rst),
      .enable  (en_q),
      .prescale (prescale_q),
      .si      (si_q),
      .restart (to_restart),
      .expire  (to_expire)
   );

   // Own-address and mask registers, one pair per entry
   for (genvar g = 0; g < 4; g++) begin : g_reg
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            own_q[g]  <= '0;
            mask_q[g] <= '0;
         end else begin
            if (wr_go && avs_req.address == OWN_OFF[g]) begin
               own_q[g] <= itam_own_t'(wd);
            end
            if (wr_go && avs_req.address == MSK_OFF[g]) begin
               mask_q[g] <= wd[7:1];
            end
         end
      end
   end

   itam_match u_match (
      .rx_valid   (rx_valid),
      .rx_addr    (rx_addr),
      .bus_master (bus_master),
      .own        (own_q),
      .mask       (mask_q),
      .hit        (m_hit),
      .gencall    (m_gencall),
      .idx        (m_idx)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addr_hit  <= 1'b0;
         gencall_hit <= 1'b0;
         hit_index <= '0;
      end else begin
         addr_hit <= m_hit;
         gencall_hit <= m_gencall;
         if (m_hit) begin
            hit_index <= m_idx;
         end
      end
   end

   // Event status: the time-out flag is bit zero, shared with the
   // time-out control view, so one write of one clears both views
   assign ev = {m_hit, state_event, to_expire};
   always_comb begin
      clr = '0;
      if (wr_sts) begin
         clr = wd[2:0];
      end
      if (wr_toc && wd[`ITAM_TOC_FLAG]) begin
         clr[`ITAM_EV_TO] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sts_q <= '0;
      end else begin
         sts_q <= (sts_q & ~clr) | ev;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ien_q <= `ITAM_IEN_RST;
      end else if (wr_ien) begin
         ien_q <= wd[2:0];
      end
   end

   // Level output; the enable bit gates every request of the controller
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= int_en_q & (|(sts_q & ien_q));
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_req_idle;
      st_q == ST_IDLE && (avs_req.read || avs_req.write);
   endsequence

   sequence s_one_ready;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   sequence s_en_off;
      !en_q ##1 !en_q;
   endsequence

   sequence s_gencall_seen;
      rx_valid && !bus_master && rx_addr[7:1] == `ITAM_GENCALL_ADDR &&
      (own_q[0].gencall_en || own_q[1].gencall_en ||
       own_q[2].gencall_en || own_q[3].gencall_en);
   endsequence

   bus_ready_a: assert property (s_req_idle |=> s_one_ready)
      else $error("bus answer not a single ready cycle");

   counter_off_a: assert property (s_en_off |-> !to_expire)
      else $error("time-out while counter disabled");

   si_restart_a: assert property (si_q |=> !to_expire)
      else $error("time-out while serial flag set");

   flag_set_a: assert property (to_expire |=> sts_q[`ITAM_EV_TO])
      else $error("time-out did not set flag");

   flag_hold_a: assert property (
      sts_q[`ITAM_EV_TO] && !clr[`ITAM_EV_TO] |=> sts_q[`ITAM_EV_TO])
      else $error("time-out flag dropped without clear");

   flag_clear_a: assert property (
      wr_toc && wd[`ITAM_TOC_FLAG] && !to_expire |=> !sts_q[`ITAM_EV_TO])
      else $error("write of one did not clear time-out flag");

   irq_gate_a: assert property (
      sts_q[`ITAM_EV_TO] && ien_q[`ITAM_EV_TO] && int_en_q |=> irq)
      else $error("time-out flag did not raise interrupt");

   irq_off_a: assert property (!int_en_q |=> !irq)
      else $error("interrupt raised with enable clear");

   master_ignore_a: assert property (bus_master |=> !addr_hit)
      else $error("address matched in master mode");

   gen_call_a: assert property (s_gencall_seen |=> addr_hit && gencall_hit)
      else $error("general call not recognised");

   si_set_a: assert property (state_event |=> si_q)
      else $error("serial flag not set by bus state");

   si_clear_a: assert property (
      wr_ctl && wd[`ITAM_CTL_SI] && !state_event |=> !si_q)
      else $error("write of one did not clear serial flag");

   mask_match_a: assert property (
      rx_valid && !bus_master && rx_addr[7:1] != `ITAM_GENCALL_ADDR &&
      ((rx_addr[7:1] ^ own_q[1].addr) & ~mask_q[1]) == '0 |=> addr_hit)
      else $error("masked address not matched");

   exact_miss_a: assert property (
      rx_valid && rx_addr[7:1] != `ITAM_GENCALL_ADDR &&
      ((rx_addr[7:1] ^ own_q[0].addr) & ~mask_q[0]) != '0 &&
      ((rx_addr[7:1] ^ own_q[1].addr) & ~mask_q[1]) != '0 &&
      ((rx_addr[7:1] ^ own_q[2].addr) & ~mask_q[2]) != '0 &&
      ((rx_addr[7:1] ^ own_q[3].addr) & ~mask_q[3]) != '0 |=> !addr_hit)
      else $error("address hit without an exact match");

   gen_call_off_a: assert property (
      rx_valid && rx_addr[7:1] == `ITAM_GENCALL_ADDR &&
      !(own_q[0].gencall_en || own_q[1].gencall_en ||
        own_q[2].gencall_en || own_q[3].gencall_en) |=> !addr_hit)
      else $error("general call matched while disabled");

   hit_status_a: assert property (addr_hit |-> sts_q[`ITAM_EV_HIT])
      else $error("address hit not recorded in status");
endmodule : itam_top

/* verification/itam_far_model.sv */
// Stand-in for the transfer machine: bus states, master role, received address bytes.
// Assumes the bench calls its tasks from one process on the system clock.
`timescale 1ns/100ps
module itam_far_model (
   input  wire logic       clk_sys,
   output logic            state_event,
   output logic            bus_master,
   output logic            rx_valid,
   output logic [7:0]      rx_addr
);
   initial begin
      state_event = 1'b0;
      bus_master  = 1'b0;
      rx_valid    = 1'b0;
      rx_addr     = 8'hA5;
   end

   // A stale byte shows its inverse, so a late sample cannot pass by luck
   task automatic send_addr(input logic [7:0] a);
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_addr  <= a;
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_addr  <= ~a;
   endtask : send_addr

   task automatic bus_state();
      @(posedge clk_sys);
      state_event <= 1'b1;
      @(posedge clk_sys);
      state_event <= 1'b0;
   endtask : bus_state

   task automatic set_master(input logic m);
      @(posedge clk_sys);
      bus_master <= m;
   endtask : set_master
endmodule : itam_far_model

/* verification/tb_top.sv */
// Self-checking bench for the time-out and address match block.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
module tb_top;
   import itam_pkg::*;
   localparam logic [13:0] LIM = 14'h0010;
   logic                   clk_sys;
   logic                   rst;
   itam_avs_req_t          avs_req;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic                   state_event;
   logic                   bus_master;
   logic                   rx_valid;
   logic [7:0]             rx_addr;
   logic                   irq;
   logic                   addr_hit;
   logic                   gencall_hit;
   logic [1:0]             hit_index;
   int                     n_fail;
   int                     n_tests;

   itam_top #(.TO_LIMIT(LIM)) itam_top_inst (
      .clk_sys(clk_sys), .rst(rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .state_event(state_event),
      .bus_master(bus_master), .rx_valid(rx_valid), .rx_addr(rx_addr), .irq(irq),
      .addr_hit(addr_hit), .gencall_hit(gencall_hit), .hit_index(hit_index));

   itam_far_model itam_far_model_inst (
      .clk_sys(clk_sys), .state_event(state_event), .bus_master(bus_master),
      .rx_valid(rx_valid), .rx_addr(rx_addr));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      if (n_fail == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until waitrequest is seen low at an edge; data taken there
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      avs_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      if (n == 20) begin
         n_fail++;
         conclude();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask : rdc

   task automatic idle_irq(input int n, input logic exp);
      repeat (n) @(posedge clk_sys);
      #1 check({31'h0, irq}, {31'h0, exp});
   endtask : idle_irq

   // Edges from here until irq rises must fall in the window
   task automatic wait_irq(input int lo, input int hi);
      int n;
      for (n = 0; n < 400; n++) begin
         @(posedge clk_sys);
         if (irq === 1'b1) break;
      end
      check(32'(n >= lo && n <= hi), 32'h1);
      if (n == 400) begin
         conclude();
      end
   endtask : wait_irq

   task automatic test_regs();
      logic [7:0]  offs [13] = '{8'h04, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
                                 8'h2C, 8'h30, 8'h44, 8'h48, 8'h3C, 8'h00};
      for (int i = 0; i < 13; i++) begin
         rdc(offs[i], (offs[i] == 8'h48) ? 32'h7 : 32'h0);
      end
      wr(8'h04, 32'hFFFFFFFF);
      rdc(8'h04, 32'hFF);
      wr(8'h30, 32'hFF);
      rdc(8'h30, 32'hFE);
      wr(8'h3C, 32'h55);
      rdc(8'h3C, 32'h0);
   endtask : test_regs

   task automatic test_match();
      logic [7:0] rx  [8] = '{8'h51, 8'h52, 8'h60, 8'h66, 8'h68, 8'h14, 8'h7E, 8'h00};
      logic [3:0] exp [8] = '{4'h8, 4'h0, 4'h9, 4'h9, 4'h1, 4'hA, 4'hB, 4'hD};
      // Software places each address in bits seven to one
      wr(8'h04, 32'h50);
      wr(8'h18, 32'h61);
      wr(8'h1C, 32'h14);
      wr(8'h20, 32'h7E);
      wr(8'h28, 32'h06);
      wr(8'h30, 32'h00);
      for (int i = 0; i < 8; i++) begin
         itam_far_model_inst.send_addr(rx[i]);
         #1 check({addr_hit, gencall_hit, hit_index}, exp[i]);
      end
      itam_far_model_inst.set_master(1'b1);
      itam_far_model_inst.send_addr(8'h51);
      #1 check({addr_hit, gencall_hit, hit_index}, 4'h1);
      itam_far_model_inst.set_master(1'b0);
      wr(8'h18, 32'h60);
      itam_far_model_inst.send_addr(8'h00);
      #1 check({addr_hit, gencall_hit, hit_index}, 4'h1);
   endtask : test_match

   task automatic test_timeout();
      rdc(8'h44, 32'h4);
      wr(8'h48, 32'h1);
      wr(8'h44, 32'h7);
      wr(8'h00, 32'h80);
      idle_irq(40, 1'b0);
      rdc(8'h14, 32'h0);
      wr(8'h14, 32'h4);
      wait_irq(16, 24);
      rdc(8'h14, 32'h5);
      wr(8'h14, 32'h4);
      rdc(8'h14, 32'h5);
      wr(8'h00, 32'h00);
      idle_irq(3, 1'b0);
      wr(8'h00, 32'h80);
      idle_irq(3, 1'b1);
      wr(8'h48, 32'h0);
      idle_irq(3, 1'b0);
      wr(8'h48, 32'h1);
      wr(8'h14, 32'h5);
      rdc(8'h14, 32'h4);
      idle_irq(40, 1'b0);
      rdc(8'h14, 32'h4);
      itam_far_model_inst.bus_state();
      rdc(8'h00, 32'h88);
      rdc(8'h44, 32'h2);
      idle_irq(40, 1'b0);
      rdc(8'h14, 32'h4);
      wr(8'h00, 32'h88);
      wait_irq(16, 24);
      wr(8'h44, 32'h1);
      rdc(8'h14, 32'h4);
      wr(8'h14, 32'h6);
      wr(8'h00, 32'h88);
      wait_irq(66, 82);
   endtask : test_timeout

   initial begin
      n_fail = 0;
      n_tests = 0;
      rst = 1'b1;
      avs_req = '0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      test_regs();
      test_match();
      test_timeout();
      conclude();
   end
endmodule : tb_top
